/* logic/qhif_host_port.sv */
// parallel and serial host port with clock, strobe and reset pins
//
// How it works
// RULE1: access counts only while chip select is low.
// RULE2: multiplexed mode latches address on falling edge of address latch.
// RULE3: address latch activity selects multiplexed versus non-multiplexed bus.
// RULE4: strobe convention: direction line high means read, low means write.
// RULE5: strobe convention: rising data strobe ends a valid read or write.
// RULE6: separate strobes: read strobe reads, write strobe writes a register.
// RULE7: non-multiplexed: seven dedicated address inputs, eight data lines.
// RULE8: indirect mode looks only at lowest dedicated address input.
// RULE9: multiplexed mode ignores the dedicated address inputs.
// RULE10: serial port clock arrives on shared line five.
// RULE11: serial data in on line six, out on line seven.
// RULE12: low reset input resets the device.
// RULE13: open-drain active-low reset output toward the system.
// RULE14: open-drain interrupt output asserted while a request is pending.
// RULE15: clock output for the attached microcontroller.
// RULE16: low wake input during power down restarts serial bus clocks.
// RULE17: two programmable slot strobes mark chosen time slots.
// RULE18: frame sync runs at 8 kHz.
// RULE19: double-rate clock runs at 1.536 MHz, twice the bit clock.
// RULE20: port type and strobe convention fixed at reset, stable afterwards.
`timescale 1ns/10ps
`default_nettype none
module qhif_host_port
  import qhif_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic              mode_serial,
  input  wire logic              mode_strobe_ds,
  input  wire logic              mode_indirect,
  input  wire logic              power_down,
  input  wire logic              irq_pending,
  input  wire logic              chip_select_n,
  input  wire logic              addr_latch,
  input  wire logic              read_strobe_n,
  input  wire logic              write_strobe_n,
  input  wire logic [DATA_W-1:0] shared_addr_data_lines_in,
  output logic      [DATA_W-1:0] shared_addr_data_lines_out,
  output logic      [DATA_W-1:0] shared_addr_data_lines_oe_n,
  input  wire logic [ADDR_W-1:0] dedicated_addr_inputs,
  input  wire logic              wake_request_n,
  output logic                   system_reset_out_n_o,
  output logic                   system_reset_out_n_oe_n,
  output logic                   host_irq_n_o,
  output logic                   host_irq_n_oe_n,
  output logic                   mcu_clk,
  output logic                   frame_sync,
  output logic                   double_rate_clock,
  output logic                   bit_rate_clock,
  output logic                   slot_strobe_one,
  output logic                   slot_strobe_two
);

  function automatic logic slot_hit(input logic [7:0] cfg, input logic [7:0] pos);
    slot_hit = cfg[STROBE_EN_BIT] && (pos[7:4] == cfg[3:0]);
  endfunction : slot_hit

  // ---------------------------------------------------------------
  // pin synchronisers and glitch filter
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pin_vec, s1_r, s2_r, s3_r, flt_r, flt_nxt;
  assign pin_vec = {dedicated_addr_inputs, shared_addr_data_lines_in, wake_request_n,
                    write_strobe_n, read_strobe_n, addr_latch, chip_select_n};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_flt
      // only an agreed second and third stage may move the filtered level
      assign flt_nxt[gi] = (s2_r[gi] == s3_r[gi]) ? s3_r[gi] : flt_r[gi];
    end
  endgenerate

  always_ff @(posedge clk) begin
    s1_r <= pin_vec;
    s2_r <= s1_r;
    s3_r <= s2_r;
    if (!rst_n) begin
      // address latch idles low: a high reset level would fake a falling edge
      flt_r         <= {SYNC_W{1'b1}};
      flt_r[IN_ALE] <= 1'b0;
    end else begin
      flt_r <= flt_nxt;
    end
  end

  logic cs_act, ale_fall, a_fall, a_rise, b_rise, a_low, b_lvl;
  logic [7:0] ad_old;
  assign cs_act   = !flt_r[IN_CS];  // see RULE1
  assign ale_fall = flt_r[IN_ALE] && !flt_nxt[IN_ALE];
  assign a_fall   = flt_r[IN_STRB_A] && !flt_nxt[IN_STRB_A];
  assign a_rise   = !flt_r[IN_STRB_A] && flt_nxt[IN_STRB_A];
  assign b_rise   = !flt_r[IN_STRB_B] && flt_nxt[IN_STRB_B];
  assign a_low    = !flt_r[IN_STRB_A];
  assign b_lvl    = flt_r[IN_STRB_B];
  assign ad_old   = flt_r[IN_AD +: 8];

  // ---------------------------------------------------------------
  // mode straps, reset output
  // ---------------------------------------------------------------
  logic serial_r, ds_r, indir_r, muxed_r, serial_nxt, ds_nxt, indir_nxt, muxed_nxt;
  logic [4:0] system_reset_out_n_r, system_reset_out_n_nxt;

  always_comb begin
    serial_nxt = serial_r;
    ds_nxt     = ds_r;
    indir_nxt  = indir_r;
    muxed_nxt  = muxed_r;
    system_reset_out_n_nxt   = system_reset_out_n_r;
    if (!rst_n) begin  // see RULE12
      serial_nxt = mode_serial;  // see RULE20
      ds_nxt     = mode_strobe_ds;
      indir_nxt  = mode_indirect;
      muxed_nxt  = 1'b0;
      system_reset_out_n_nxt   = 5'(SYSTEM_RESET_OUT_N_CYC);
    end else begin
      if (ale_fall && !serial_r) begin
        muxed_nxt = 1'b1;  // see RULE3
      end
      if (system_reset_out_n_r != 5'h00) begin
        system_reset_out_n_nxt = system_reset_out_n_r - 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    serial_r <= serial_nxt;
    ds_r     <= ds_nxt;
    indir_r  <= indir_nxt;
    muxed_r  <= muxed_nxt;
    system_reset_out_n_r   <= system_reset_out_n_nxt;
  end

  assign system_reset_out_n_o    = 1'b0;
  assign system_reset_out_n_oe_n = (system_reset_out_n_r == 5'h00);  // see RULE13
  assign host_irq_n_o            = 1'b0;
  assign host_irq_n_oe_n         = !irq_pending;  // see RULE14

  // ---------------------------------------------------------------
  // parallel access decode
  // ---------------------------------------------------------------
  logic [6:0] lat_r, lat_nxt, ptr_r, ptr_nxt, ea;
  logic       rd_start, rd_act, wr_end, use_ptr;
  logic [7:0] dout_r, dout_nxt;
  logic       rdpend_r, rdpend_nxt;

  assign rd_start = !serial_r && cs_act && a_fall && (ds_r ? b_lvl : 1'b1);  // see RULE4
  assign rd_act   = !serial_r && cs_act && a_low && (ds_r ? b_lvl : 1'b1);  // see RULE6
  assign wr_end   = !serial_r && cs_act && (ds_r ? (a_rise && !b_lvl) : b_rise);  // see RULE5
  // see RULE9
  assign ea       = muxed_r ? lat_r
                  : indir_r ? {6'h00, flt_r[IN_A]}  // see RULE8
                  : flt_r[IN_A +: 7];  // see RULE7
  assign use_ptr  = indir_r && !ea[0];

  logic       ser_re, ser_we;
  logic [6:0] ser_addr;
  logic [7:0] ser_wdata, mem_rdata;
  logic       mem_we, mem_re;
  logic [6:0] mem_waddr, mem_raddr;
  logic [7:0] mem_wdata;

  assign mem_re    = (rd_start && !use_ptr) || ser_re;
  assign mem_raddr = serial_r ? ser_addr : (indir_r ? ptr_r : ea);
  assign mem_we    = (wr_end && !use_ptr) || ser_we;
  assign mem_waddr = mem_raddr;
  assign mem_wdata = serial_r ? ser_wdata : ad_old;

  always_comb begin
    lat_nxt    = lat_r;
    ptr_nxt    = ptr_r;
    dout_nxt   = dout_r;
    rdpend_nxt = 1'b0;
    if (ale_fall) begin
      lat_nxt = flt_r[IN_AD +: 7];  // see RULE2
    end
    if (wr_end && use_ptr) begin
      ptr_nxt = ad_old[6:0];
    end
    if (rd_start) begin
      rdpend_nxt = !use_ptr;
      if (use_ptr) begin
        dout_nxt = {1'b0, ptr_r};
      end
    end
    if (rdpend_r) begin
      dout_nxt = mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lat_r    <= 7'h00;
      ptr_r    <= 7'h00;
      dout_r   <= 8'h00;
      rdpend_r <= 1'b0;
    end else begin
      lat_r    <= lat_nxt;
      ptr_r    <= ptr_nxt;
      dout_r   <= dout_nxt;
      rdpend_r <= rdpend_nxt;
    end
  end

  qhif_regmem #(.AW(ADDR_W), .DW(DATA_W)) u_mem (
    .clk   (clk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .re    (mem_re),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ---------------------------------------------------------------
  // serial port: 8 header bits (read flag, address) then 8 data bits
  // ---------------------------------------------------------------
  logic [4:0] scnt_r, scnt_nxt;
  logic [7:0] sin_r, sin_nxt, hdr_r, hdr_nxt, sout_r, sout_nxt;
  logic       sload_r, sload_nxt, sclk_rise, sclk_fall, sin_bit;

  assign sclk_rise = !flt_r[IN_AD + SER_CLK_BIT] && flt_nxt[IN_AD + SER_CLK_BIT];  // see RULE10
  assign sclk_fall = flt_r[IN_AD + SER_CLK_BIT] && !flt_nxt[IN_AD + SER_CLK_BIT];
  assign sin_bit   = flt_r[IN_AD + SER_RX_BIT];  // see RULE11
  assign sin_nxt   = sclk_rise ? {sin_r[6:0], sin_bit} : sin_r;
  assign ser_re    = serial_r && cs_act && sclk_rise && (scnt_r == SER_HDR_BITS - 5'h01)
                     && sin_r[6];
  assign ser_we    = serial_r && cs_act && sclk_rise && (scnt_r == SER_LAST_BIT - 5'h01)
                     && !hdr_r[7];
  assign ser_addr  = (scnt_r == SER_HDR_BITS - 5'h01) ? {sin_r[5:0], sin_bit} : hdr_r[6:0];
  assign ser_wdata = {sin_r[6:0], sin_bit};

  always_comb begin
    scnt_nxt  = scnt_r;
    hdr_nxt   = hdr_r;
    sout_nxt  = sout_r;
    sload_nxt = ser_re;
    if (!cs_act || !serial_r) begin
      scnt_nxt = 5'h00;
    end else if (sclk_rise && scnt_r != SER_LAST_BIT) begin
      scnt_nxt = scnt_r + 5'h01;
      if (scnt_r == SER_HDR_BITS - 5'h01) begin
        hdr_nxt = {sin_r[6:0], sin_bit};
      end
    end
    if (sload_r) begin
      sout_nxt = mem_rdata;
    end else if (sclk_fall && scnt_r > SER_HDR_BITS) begin
      sout_nxt = {sout_r[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scnt_r  <= 5'h00;
      sin_r   <= 8'h00;
      hdr_r   <= 8'h00;
      sout_r  <= 8'h00;
      sload_r <= 1'b0;
    end else begin
      scnt_r  <= scnt_nxt;
      sin_r   <= sin_nxt;
      hdr_r   <= hdr_nxt;
      sout_r  <= sout_nxt;
      sload_r <= sload_nxt;
    end
  end

  always_comb begin
    shared_addr_data_lines_out  = dout_r;
    shared_addr_data_lines_oe_n = {8{!rd_act}};
    if (serial_r) begin
      shared_addr_data_lines_out  = {sout_r[7], 7'h00};  // see RULE11
      shared_addr_data_lines_oe_n = {!(cs_act && hdr_r[7] && scnt_r >= SER_HDR_BITS), 7'h7f};
    end
  end

  // ---------------------------------------------------------------
  // serial bus clocks, frame sync, slot strobes, micro clock
  // ---------------------------------------------------------------
  logic       run;
  logic [7:0] div_r, div_nxt, pos_r, pos_nxt, st1_r, st1_nxt, st2_r, st2_nxt;
  logic [2:0] mdiv_r, mdiv_nxt;
  logic       dcl_r, dcl_nxt, bcl_r, bcl_nxt, mclk_r, mclk_nxt;

  // a stopped bus restarts at frame start, so no partial frame is seen
  assign run = !power_down || !flt_r[IN_WAKE];  // see RULE16

  always_comb begin
    div_nxt  = div_r;
    dcl_nxt  = dcl_r;
    bcl_nxt  = bcl_r;
    pos_nxt  = pos_r;
    mdiv_nxt = mdiv_r + 3'h1;
    mclk_nxt = mclk_r;
    st1_nxt  = st1_r;
    st2_nxt  = st2_r;
    if (!run) begin
      div_nxt = 8'h00;
      dcl_nxt = 1'b0;
      bcl_nxt = 1'b0;
      pos_nxt = 8'h00;
    end else if (div_r == 8'(DCL_HALF_CYC - 1)) begin  // see RULE19
      div_nxt = 8'h00;
      dcl_nxt = !dcl_r;
      if (dcl_r) begin
        bcl_nxt = !bcl_r;
        pos_nxt = (pos_r == 8'(DCL_PER_FRAME - 1)) ? 8'h00 : pos_r + 8'h01;  // see RULE18
      end
    end else begin
      div_nxt = div_r + 8'h01;
    end
    if (mdiv_r == 3'(MCLK_HALF_CYC - 1)) begin
      mdiv_nxt = 3'h0;
      mclk_nxt = !mclk_r;  // see RULE15
    end
    if (mem_we && mem_waddr == STROBE1_ADDR) begin
      st1_nxt = mem_wdata;
    end
    if (mem_we && mem_waddr == STROBE2_ADDR) begin
      st2_nxt = mem_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_r  <= 8'h00;
      dcl_r  <= 1'b0;
      bcl_r  <= 1'b0;
      pos_r  <= 8'h00;
      mdiv_r <= 3'h0;
      mclk_r <= 1'b0;
      st1_r  <= STROBE_RST;
      st2_r  <= STROBE_RST;
    end else begin
      div_r  <= div_nxt;
      dcl_r  <= dcl_nxt;
      bcl_r  <= bcl_nxt;
      pos_r  <= pos_nxt;
      mdiv_r <= mdiv_nxt;
      mclk_r <= mclk_nxt;
      st1_r  <= st1_nxt;
      st2_r  <= st2_nxt;
    end
  end

  assign double_rate_clock = dcl_r;
  assign bit_rate_clock    = bcl_r;
  assign frame_sync        = run && (pos_r < 8'h02);  // see RULE18
  assign mcu_clk           = mclk_r;
  assign slot_strobe_one   = run && slot_hit(st1_r, pos_r);  // see RULE17
  assign slot_strobe_two   = run && slot_hit(st2_r, pos_r);  // see RULE17

endmodule : qhif_host_port
`default_nettype wire

/* logic/qhif_regmem.sv */
// register store behind the host port, registered read
`timescale 1ns/10ps
`default_nettype none
module qhif_regmem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input  wire logic          clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (re) begin
      rdata <= mem[raddr];
    end
  end

endmodule : qhif_regmem
`default_nettype wire

/* pkg/qhif_pkg.sv */
// constants shared by the host microcontroller port
package qhif_pkg;

  // ---------------------------------------------------------------
  // bus widths
  // ---------------------------------------------------------------
  localparam int ADDR_W      = 7;
  localparam int DATA_W      = 8;
  localparam int SYNC_W      = 20;

  // ---------------------------------------------------------------
  // bit positions inside the synchroniser vector
  // ---------------------------------------------------------------
  localparam int IN_CS       = 0;
  localparam int IN_ALE      = 1;
  localparam int IN_STRB_A   = 2;
  localparam int IN_STRB_B   = 3;
  localparam int IN_WAKE     = 4;
  localparam int IN_AD       = 5;
  localparam int IN_A        = 13;

  // ---------------------------------------------------------------
  // serial port pin use on the shared lines
  // ---------------------------------------------------------------
  localparam int SER_CLK_BIT = 5;
  localparam int SER_RX_BIT  = 6;
  localparam int SER_TX_BIT  = 7;
  localparam logic [4:0] SER_HDR_BITS  = 5'h08;
  localparam logic [4:0] SER_LAST_BIT  = 5'h10;

  // ---------------------------------------------------------------
  // internal register addresses for the slot strobes
  // ---------------------------------------------------------------
  localparam logic [6:0] STROBE1_ADDR  = 7'h30;
  localparam logic [6:0] STROBE2_ADDR  = 7'h31;
  localparam logic [7:0] STROBE_RST    = 8'h00;
  localparam int STROBE_EN_BIT = 7;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam longint CLK_HZ        = 250000000;
  localparam longint DCL_HZ        = 1536000;
  localparam longint FSC_HZ        = 8000;
  localparam int     DCL_HALF_CYC  = int'(CLK_HZ / (2 * DCL_HZ));
  localparam int     DCL_PER_FRAME = int'(DCL_HZ / FSC_HZ);
  localparam int     MCLK_HALF_CYC = 4;
  localparam int     SYSTEM_RESET_OUT_N_CYC      = 16;

endpackage : qhif_pkg

/* sim/qhif_host_model.sv */
// behavioural microcontroller driving the host port pins
`timescale 1ns/10ps
`default_nettype none
module qhif_host_model
  import qhif_pkg::*;
(
  input  wire logic              clk,
  output logic                   chip_select_n,
  output logic                   addr_latch,
  output logic                   read_strobe_n,
  output logic                   write_strobe_n,
  output logic      [DATA_W-1:0] shared_addr_data_lines_in,
  input  wire logic [DATA_W-1:0] shared_addr_data_lines_out,
  input  wire logic [DATA_W-1:0] shared_addr_data_lines_oe_n,
  output logic      [ADDR_W-1:0] dedicated_addr_inputs
);
  logic [DATA_W-1:0] drv_val;
  logic [DATA_W-1:0] drv_en;
  logic [DATA_W-1:0] junk;
  // ----
  // wire level
  // ----
  // released lines wander every cycle so a stale value never passes
  always @(posedge clk) junk <= junk + 8'h5b;
  assign shared_addr_data_lines_in =
    (~shared_addr_data_lines_oe_n & shared_addr_data_lines_out) |
    (shared_addr_data_lines_oe_n & ((drv_en & drv_val) | (~drv_en & junk)));
  initial begin
    junk = 8'h00;
    drv_val = 8'h00;
    drv_en = 8'h00;
    chip_select_n = 1'h1;
    addr_latch = 1'h0;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    dedicated_addr_inputs = 7'h00;
  end
  // ----
  // transfers
  // ----
  task automatic par_acc(input logic mux, input logic ds, input logic rd, input logic nocs,
                         input logic [6:0] addr, input logic [7:0] wd, output logic [7:0] rdv);
    @(negedge clk);
    dedicated_addr_inputs = addr;
    if (mux) begin
      addr_latch = 1'h1;
      drv_en = 8'hff;
      drv_val = {1'h0, addr};
      dedicated_addr_inputs = ~addr;
      repeat (8) @(negedge clk);
      addr_latch = 1'h0;
      repeat (8) @(negedge clk);
    end
    chip_select_n = nocs;
    drv_en = rd ? 8'h00 : 8'hff;
    drv_val = wd;
    write_strobe_n = ds ? rd : 1'h1;
    repeat (8) @(negedge clk);
    if (ds || rd) read_strobe_n = 1'h0;
    else write_strobe_n = 1'h0;
    repeat (12) @(negedge clk);
    rdv = shared_addr_data_lines_in;
    read_strobe_n = 1'h1;
    if (!ds) write_strobe_n = 1'h1;
    repeat (8) @(negedge clk);
    chip_select_n = 1'h1;
    drv_en = 8'h00;
    repeat (8) @(negedge clk);
  endtask : par_acc
  // serial clock rests low outside frames
  task automatic ser_acc(input logic [15:0] frm, output logic [7:0] rdv);
    integer i;
    @(negedge clk);
    drv_en = 8'h60;
    drv_val = 8'h00;
    repeat (10) @(negedge clk);
    chip_select_n = 1'h0;
    for (i = 0; i < 16; i++) begin
      drv_val = {1'h0, frm[15-i], 6'h00};
      repeat (10) @(negedge clk);
      drv_val[SER_CLK_BIT] = 1'h1;
      repeat (10) @(negedge clk);
      // bit 7 stands until the fall after the ninth rise, so sample rises 9 to 16
      if (i >= 8) rdv[15-i] = shared_addr_data_lines_in[SER_TX_BIT];
    end
    drv_val = 8'h00;
    repeat (10) @(negedge clk);
    chip_select_n = 1'h1;
    drv_en = 8'h20;
    repeat (10) @(negedge clk);
  endtask : ser_acc
endmodule : qhif_host_model
`default_nettype wire

/* sim/qhif_host_port_sva.sv */
// pin-level assertion checker for the host port
`timescale 1ns/10ps
`default_nettype none
module qhif_host_port_sva
  import qhif_pkg::*;
(
  input wire logic              clk,
  input wire logic              rst_n,
  input wire logic              power_down,
  input wire logic              irq_pending,
  input wire logic              chip_select_n,
  input wire logic [DATA_W-1:0] shared_addr_data_lines_oe_n,
  input wire logic              system_reset_out_n_o,
  input wire logic              system_reset_out_n_oe_n,
  input wire logic              host_irq_n_oe_n,
  input wire logic              mcu_clk,
  input wire logic              frame_sync,
  input wire logic              double_rate_clock,
  input wire logic              bit_rate_clock
);
  localparam int FS_HIGH = 4 * DCL_HALF_CYC;
  localparam int FS_PER  = 2 * DCL_HALF_CYC * DCL_PER_FRAME;
  // ----
  // frame counter
  // ----
  // restarts at power down since the frame timing is broken there anyway
  logic [15:0] fs_cnt_r;
  logic        fs_q_r;
  logic        fs_seen_r;
  always_ff @(posedge clk) begin
    if (!rst_n || power_down) begin
      fs_cnt_r  <= 16'h0000;
      fs_q_r    <= 1'h0;
      fs_seen_r <= 1'h0;
    end else begin
      fs_q_r   <= frame_sync;
      fs_cnt_r <= (frame_sync && !fs_q_r) ? 16'h0001 : fs_cnt_r + 16'h0001;
      fs_seen_r <= fs_seen_r || (frame_sync && !fs_q_r);
    end
  end
  // ----
  // assertions
  // ----
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_irq_follow: assert property (host_irq_n_oe_n == !irq_pending)
    else $error("interrupt pin does not follow pending request");
  chk_reset_state: assert property (disable iff (1'h0)
    !rst_n |=> (&shared_addr_data_lines_oe_n) && !system_reset_out_n_oe_n)
    else $error("outputs not in reset state");
  chk_system_reset_out_n_stretch: assert property ($rose(rst_n) |->
    ##15 !system_reset_out_n_oe_n ##[1:4] system_reset_out_n_oe_n)
    else $error("reset output stretch wrong");
  chk_system_reset_out_n_level: assert property (!system_reset_out_n_oe_n |-> !system_reset_out_n_o)
    else $error("reset output not pulled low");
  chk_mclk_half: assert property (disable iff (!rst_n || power_down)
    $rose(mcu_clk) |-> mcu_clk [*4] ##1 !mcu_clk)
    else $error("controller clock half period wrong");
  chk_dcl_half: assert property (disable iff (!rst_n || power_down)
    $rose(double_rate_clock) |-> ##80 double_rate_clock ##1 !double_rate_clock)
    else $error("double rate clock half period wrong");
  chk_bcl_half: assert property (disable iff (!rst_n || power_down)
    $rose(bit_rate_clock) |-> ##161 bit_rate_clock ##1 !bit_rate_clock)
    else $error("bit clock half period wrong");
  chk_fs_width: assert property (disable iff (!rst_n || power_down)
    $fell(frame_sync) |-> fs_cnt_r == FS_HIGH)
    else $error("frame sync width wrong");
  chk_fs_period: assert property (disable iff (!rst_n || power_down)
    frame_sync && !fs_q_r && fs_seen_r |-> fs_cnt_r == FS_PER)
    else $error("frame sync period wrong");
  chk_cs_release: assert property (chip_select_n [*8] |-> &shared_addr_data_lines_oe_n)
    else $error("bus driven without chip select");
endmodule : qhif_host_port_sva
bind qhif_host_port qhif_host_port_sva qhif_host_port_sva_i (
  .clk, .rst_n, .power_down, .irq_pending, .chip_select_n, .shared_addr_data_lines_oe_n,
  .system_reset_out_n_o, .system_reset_out_n_oe_n, .host_irq_n_oe_n, .mcu_clk,
  .frame_sync, .double_rate_clock, .bit_rate_clock
);
`default_nettype wire

/* sim/test_host_microcontroller_interface.sv */
// self-checking bench for the host microcontroller port
`timescale 1ns/10ps
`default_nettype none
module test_host_microcontroller_interface
  import qhif_pkg::*;
;
  localparam int SLOT = 32 * DCL_HALF_CYC;
  logic clk, rst_n, mode_serial, mode_strobe_ds, mode_indirect, power_down, irq_pending;
  logic chip_select_n, addr_latch, read_strobe_n, write_strobe_n, wake_request_n, mcu_clk;
  logic system_reset_out_n_o, system_reset_out_n_oe_n, host_irq_n_o, host_irq_n_oe_n;
  logic frame_sync, double_rate_clock, bit_rate_clock, slot_strobe_one, slot_strobe_two;
  logic [DATA_W-1:0] shared_addr_data_lines_in, shared_addr_data_lines_out;
  logic [DATA_W-1:0] shared_addr_data_lines_oe_n, rd_v, dq [6];
  logic [ADDR_W-1:0] dedicated_addr_inputs, aq [6];
  integer            seed, miscompares, checks_done, i, n, sl [2], st0 [2], hi [2];
  qhif_host_port qhif_host_port_i (
    .clk, .rst_n, .mode_serial, .mode_strobe_ds, .mode_indirect, .power_down, .irq_pending,
    .chip_select_n, .addr_latch, .read_strobe_n, .write_strobe_n, .shared_addr_data_lines_in,
    .shared_addr_data_lines_out, .shared_addr_data_lines_oe_n, .dedicated_addr_inputs,
    .wake_request_n, .system_reset_out_n_o, .system_reset_out_n_oe_n, .host_irq_n_o,
    .host_irq_n_oe_n, .mcu_clk, .frame_sync, .double_rate_clock, .bit_rate_clock,
    .slot_strobe_one, .slot_strobe_two
  );
  qhif_host_model qhif_host_model_i (
    .clk, .chip_select_n, .addr_latch, .read_strobe_n, .write_strobe_n,
    .shared_addr_data_lines_in, .shared_addr_data_lines_out, .shared_addr_data_lines_oe_n,
    .dedicated_addr_inputs
  );
  always #2 clk = ~clk;
  // ----
  // helpers
  // ----
  task automatic final_report();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_byte
  task automatic chk_cnt(input integer got, input integer exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_cnt
  // flags are mux, data strobe convention, read, chip select held high
  task automatic acc(input logic [3:0] f, input logic [6:0] a, input logic [7:0] w);
    qhif_host_model_i.par_acc(f[3], f[2], f[1], f[0], a, w, rd_v);
  endtask : acc
  task automatic do_reset(input logic s, input logic d, input logic x);
    @(negedge clk);
    {mode_serial, mode_strobe_ds, mode_indirect} = {s, d, x};
    rst_n = 1'h0;
    repeat (6) @(negedge clk);
    chk_byte(shared_addr_data_lines_oe_n, 8'hff);
    chk_byte({7'h00, system_reset_out_n_oe_n}, 8'h00);
    rst_n = 1'h1;
    repeat (20) @(negedge clk);
    chk_byte({7'h00, system_reset_out_n_oe_n}, 8'h01);
  endtask : do_reset
  task automatic wait_fs(input logic v);
    for (n = 0; frame_sync !== v; n++) begin
      if (n > 40000) begin
        miscompares++;
        final_report();
      end
      @(negedge clk);
    end
  endtask : wait_fs
  task automatic toggles(output integer t);
    logic b;
    t = 0;
    for (n = 0; n < 400; n++) begin
      b = double_rate_clock;
      @(negedge clk);
      if (double_rate_clock !== b) t++;
    end
  endtask : toggles
  // ----
  // scenarios
  // ----
  initial begin
    {clk, rst_n, mode_serial, mode_strobe_ds, mode_indirect, power_down} = 6'h00;
    {irq_pending, wake_request_n} = 2'h1;
    seed = 32763;
    miscompares = 0;
    checks_done = 0;
    do_reset(1'h0, 1'h0, 1'h0);
    for (i = 0; i < 6; i++) begin
      aq[i] = {1'h1, i[2:0], 3'($random(seed))};
      dq[i] = 8'($random(seed));
      acc(4'h0, aq[i], dq[i]);
      irq_pending = 1'($random(seed));
      @(negedge clk);
      chk_byte({7'h00, host_irq_n_oe_n}, {7'h00, ~irq_pending});
    end
    acc(4'h1, aq[0], ~dq[0]);
    for (i = 0; i < 6; i++) begin
      acc(4'h2, aq[i], 8'h00);
      chk_byte(rd_v, dq[i]);
    end
    acc(4'ha, aq[1], 8'h00);
    chk_byte(rd_v, dq[1]);
    acc(4'h8, aq[2], 8'h5a);
    acc(4'ha, aq[2], 8'h00);
    chk_byte(rd_v, 8'h5a);
    do_reset(1'h0, 1'h1, 1'h0);
    acc(4'h4, aq[3], 8'hc3);
    acc(4'h6, aq[3], 8'h00);
    chk_byte(rd_v, 8'hc3);
    do_reset(1'h0, 1'h0, 1'h1);
    acc(4'h0, {6'($random(seed)), 1'h0}, {1'h0, aq[4]});
    acc(4'h2, {6'($random(seed)), 1'h0}, 8'h00);
    chk_byte(rd_v, {1'h0, aq[4]});
    acc(4'h2, {6'($random(seed)), 1'h1}, 8'h00);
    chk_byte(rd_v, dq[4]);
    do_reset(1'h1, 1'h0, 1'h0);
    qhif_host_model_i.ser_acc({1'h0, aq[5], 8'h96}, rd_v);
    qhif_host_model_i.ser_acc({1'h1, aq[5], 8'h00}, rd_v);
    chk_byte(rd_v, 8'h96);
    do_reset(1'h0, 1'h0, 1'h0);
    for (i = 0; i < 2; i++) begin
      sl[i] = $unsigned($random(seed)) % 12;
      st0[i] = -1;
      hi[i] = 0;
      acc(4'h0, i ? STROBE2_ADDR : STROBE1_ADDR, {4'h8, 4'(sl[i])});
    end
    wait_fs(1'h0);
    wait_fs(1'h1);
    // one whole frame of twelve slots, both strobes watched together
    for (n = 0; n < 12 * SLOT; n++) begin
      for (i = 0; i < 2; i++) begin
        if ((i ? slot_strobe_two : slot_strobe_one) === 1'h1) begin
          if (hi[i] == 0) st0[i] = n;
          hi[i]++;
        end
      end
      @(negedge clk);
    end
    for (i = 0; i < 2; i++) begin
      chk_cnt(st0[i], sl[i] * SLOT);
      chk_cnt(hi[i], SLOT);
    end
    power_down = 1'h1;
    repeat (400) @(negedge clk);
    toggles(hi[0]);
    chk_cnt(hi[0], 0);
    wake_request_n = 1'h0;
    toggles(hi[0]);
    chk_cnt(hi[0] > 3, 1);
    final_report();
  end
endmodule : test_host_microcontroller_interface
`default_nettype wire
